// ### dv/dsie_engine_asserts.sv
// dsie_engine_asserts.sv: port-level checks of the integrator engine
// assumes bind onto dsie_engine in the bench top, one clock domain
`timescale 1ns/1ps

module dsie_engine_asserts (
    input wire clock,
    input wire rst_n,
    input wire timing_pulse_pin,
    input wire rd_en,
    input wire [31:0] rd_data_q,
    input wire [5:0] pos_q,
    input wire [4:0] sect_q,
    input wire dz_q,
    input wire dz_valid_q,
    input wire revolution_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence last_slot_s;
        pos_q == 6'h30 && sect_q == 5'h15;
    endsequence
    sequence first_slot_s;
        pos_q == 6'h01;
    endsequence

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_pos_range: assert property (pos_q >= 6'h01 && pos_q <= 6'h30)
        else $error("position out of range");
    chk_pos_step: assert property ($changed(pos_q) |->
        (pos_q == $past(pos_q) + 6'h01) || (pos_q == 6'h01 && $past(pos_q) == 6'h30))
        else $error("position did not advance by one");
    chk_pos_cause: assert property ($changed(pos_q) |->
        $past(timing_pulse_pin, 2) || $past(timing_pulse_pin, 3) || $past(timing_pulse_pin, 4))
        else $error("position moved without a timing pulse");
    chk_sect_step: assert property ($changed(sect_q) |->
        $past(pos_q) == 6'h30 && pos_q == 6'h01 &&
        (sect_q == $past(sect_q) + 5'h01 || sect_q == 5'h00))
        else $error("section moved outside a section end");
    chk_sect_range: assert property (sect_q <= 5'h15)
        else $error("section out of range");
    chk_rev_wrap: assert property (last_slot_s ##1 first_slot_s |-> revolution_q)
        else $error("missing revolution pulse");
    chk_rev_only: assert property (revolution_q |->
        sect_q == 5'h00 && pos_q == 6'h01 && $past(sect_q) == 5'h15)
        else $error("revolution pulse away from wrap");
    chk_dz_pulse: assert property (dz_valid_q |=> !dz_valid_q)
        else $error("output increment strobe longer than one cycle");
    chk_dz_hold: assert property ($changed(dz_q) |-> dz_valid_q)
        else $error("output increment changed without strobe");
    chk_dz_slot: assert property (dz_valid_q |-> pos_q == 6'h01 || pos_q == 6'h30)
        else $error("output increment away from section end");
    chk_rd_idle: assert property (!$past(rd_en) |-> rd_data_q == 32'h00000000)
        else $error("read data outside read cycle");
endmodule // dsie_engine_asserts

// ### dv/dsie_engine_bench.sv
// dsie_engine_bench.sv: self-checking bench of the integrator engine
// assumes the engine and its track memory compiled from rtl/
`timescale 1ns/1ps

module dsie_engine_bench;
    reg clock;
    reg rst_n;
    reg timing_pulse_pin;
    reg [3:0] addr;
    reg [31:0] wr_data;
    reg wr_en;
    reg rd_en;
    wire [31:0] rd_data_q;
    wire [5:0] pos_q;
    wire [4:0] sect_q;
    wire dz_q;
    wire dz_valid_q;
    wire revolution_q;
    integer mismatches;
    integer total_checks;
    integer seed;
    integer rev_count;
    integer dz_count;
    integer steps_done;
    integer i;
    reg [31:0] rv;
    reg [31:0] lo;
    reg [3:0] ua;
    reg dz_log [0:63];

    dsie_engine u_dsie_engine (
        .clock(clock),
        .rst_n(rst_n),
        .timing_pulse_pin(timing_pulse_pin),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data_q(rd_data_q),
        .pos_q(pos_q),
        .sect_q(sect_q),
        .dz_q(dz_q),
        .dz_valid_q(dz_valid_q),
        .revolution_q(revolution_q)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // monitors and helpers
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (dz_valid_q === 1'b1 && dz_count < 64) begin
            dz_log[dz_count] <= dz_q;
            dz_count <= dz_count + 1;
        end
        if (revolution_q === 1'b1) begin
            rev_count <= rev_count + 1;
        end
    end

    function [31:0] exp_place(input integer s);
        integer m;
        begin
            m = s % 1056;
            exp_place = ((m / 48) << 8) | ((m % 48) + 1);
        end
    endfunction

    task check(input string what, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clock);
            addr <= a;
            wr_data <= d;
            wr_en <= 1'b1;
            @(posedge clock);
            wr_en <= 1'b0;
        end
    endtask

    task rd(input [3:0] a, output [31:0] v);
        begin
            @(posedge clock);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clock);
            rd_en <= 1'b0;
            @(negedge clock);
            v = rd_data_q;
        end
    endtask

    task steps(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                @(posedge clock);
                timing_pulse_pin <= 1'b1;
                repeat (3) @(posedge clock);
                timing_pulse_pin <= 1'b0;
                repeat (3) @(posedge clock);
            end
            steps_done = steps_done + n;
        end
    endtask

    task complete_run;
        begin
            if (mismatches == 0 && total_checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    initial begin
        #1200000;
        mismatches = mismatches + 1;
        complete_run;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'hDFD1F2CE;
        mismatches = 0;
        total_checks = 0;
        rev_count = 0;
        dz_count = 0;
        steps_done = 0;
        rst_n = 1'b0;
        timing_pulse_pin = 1'b0;
        addr = 4'h0;
        wr_data = 32'h00000000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        // reset state and unmapped places
        rd(4'h1, rv);
        check("status", 32'h00000001, rv & 32'h00F31F3F);
        rd(4'h4, rv);
        check("zline_lo", 32'h00000000, rv);
        for (i = 0; i < 3; i = i + 1) begin
            wr(4'h0, i << 1);
            rd(4'h0, rv);
            check("ctrl_zlen", i << 1, rv);
        end
        for (i = 0; i < 4; i = i + 1) begin
            ua = 4'h6 + ($random(seed) & 32'h7);
            wr(ua, $random(seed));
            rd(ua, rv);
            check("unmapped", 32'h00000000, rv);
        end
        wr(4'h0, 32'h00000000);
        // random stepping, then finish one revolution
        for (i = 0; i < 3; i = i + 1) begin
            steps(($random(seed) & 32'hFF) + 1);
            rd(4'h1, rv);
            check("place", exp_place(steps_done), rv & 32'h00001F3F);
            check("place_port", exp_place(steps_done), {19'h00000, sect_q, 2'h0, pos_q});
        end
        steps(1056 - steps_done);
        rd(4'h1, rv);
        check("wrap_place", 32'h00000001, rv & 32'h00001F3F);
        check("revolutions", 32'h00000001, rev_count);
        // fill remainder then integrand tracks
        wr(4'h2, 32'h00000000);
        for (i = 0; i < 1056; i = i + 1) begin
            wr(4'h3, (i == 0) ? 32'h1 : 32'h0);
        end
        wr(4'h2, 32'h00001000);
        for (i = 0; i < 1056; i = i + 1) begin
            wr(4'h3, (i == 23 || i == 24 || (i >= 48 && i <= 55)) ? 32'h1 : 32'h0);
        end
        // compute two sections
        wr(4'h0, 32'h00000001);
        steps(70);
        rd(4'h1, rv);
        check("counter", 32'h00900117, rv & 32'h00F31F3F);
        steps(26);
        check("dz_count", 32'h00000002, dz_count);
        check("dz_first", 32'h00000001, dz_log[0]);
        check("dz_second", 32'h00000000, dz_log[1]);
        rd(4'h4, lo);
        rd(4'h5, rv);
        check("zline_set", 32'h00000001, ((lo | rv) != 32'h0) ? 32'h1 : 32'h0);
        check("zline_out_lo", 32'h00000000, lo);
        check("zline_out_hi", 32'h00010000, rv);
        // idle recirculation at each line length
        wr(4'h0, 32'h00000000);
        steps(1);
        rd(4'h4, lo);
        rd(4'h5, rv);
        check("zline_49_lo", 32'h00000001, lo);
        check("zline_49_hi", 32'h00000000, rv);
        wr(4'h0, 32'h00000004);
        steps(47);
        rd(4'h4, lo);
        rd(4'h5, rv);
        check("zline_47_lo", 32'h00000001, lo);
        check("zline_47_hi", 32'h00008000, rv);
        wr(4'h0, 32'h00000002);
        steps(1);
        rd(4'h4, lo);
        rd(4'h5, rv);
        check("zline_48_lo", 32'h00000003, lo);
        check("zline_48_hi", 32'h00010000, rv);
        wr(4'h0, 32'h00000009);
        rd(4'h4, lo);
        rd(4'h5, rv);
        check("zline_clear", 32'h00000000, lo | rv);
        wr(4'h0, 32'h00000000);
        complete_run;
    end
endmodule // dsie_engine_bench

bind dsie_engine dsie_engine_asserts u_dsie_engine_asserts (
    .clock(clock),
    .rst_n(rst_n),
    .timing_pulse_pin(timing_pulse_pin),
    .rd_en(rd_en),
    .rd_data_q(rd_data_q),
    .pos_q(pos_q),
    .sect_q(sect_q),
    .dz_q(dz_q),
    .dz_valid_q(dz_valid_q),
    .revolution_q(revolution_q)
);

// ### rtl/dsie_engine.v
// dsie_engine.v: bit-serial integrator engine stepping 22 drum sections
// assumes timing pulses arrive on a pin, each high and low for >= 2 clocks
//
// Contract
// RULE1: each section spans 48 positions; 1..24 code, 25..48 numeric data
// RULE2: remainder and integrand tracks hold 22 sections, processed by one datapath
// RULE3: remainder code positions 1..22 carry one pickup selecting dx source
// RULE4: remainder code positions 23 and 24 are blank and ignored
// RULE5: pickup with overflow line latches direction; one adds, zero adds complement
// RULE6: remainder and integrand LSD share a position between 25 and 46
// RULE7: remainder position 47 holds its most significant digit
// RULE8: position 48 adder digit goes to overflow line as output increment
// RULE9: integrand code picks up to seven increments into increment counter
// RULE10: pickup counts up for one, down for zero; total added after start
// RULE11: integrand code position 23 is blank
// RULE12: first integrand pulse after 23 is start, enabling numeric work
// RULE13: integrand position 47 is its sign digit, pulse means positive
// RULE14: integrand position 48 reads zero and is rewritten as zero
// RULE15: overflow line is 49 long, selectable 47 or 48 for filling
// RULE16: precession puts successive outputs one position later each section
// RULE17: position counter counts timing pulses modulo 48, pulses per section
// RULE18: section counter of 22 counts section pulses; indexes track bits
// RULE19: overflow line recirculates except at 48, where adder digit enters
// RULE20: numeric half writes adder results back except at position 48
// RULE21: remainder bit at position 48 is recirculated unchanged
// RULE22: both adders are serial with one-pulse carry delay
// RULE23: at position 24 main carry presets zero for add, one for subtract
// RULE24: present pulse counts plus one unit, absent pulse minus one
// RULE25: increment counter holds +-7, stepped in after start, cleared after 48
// RULE26: section counter wraps last to first, one pass per revolution
`timescale 1ns/1ps
`include "dsie_regs.vh"

module dsie_engine (
    clock,
    rst_n,
    timing_pulse_pin,
    addr,
    wr_data,
    wr_en,
    rd_en,
    rd_data_q,
    pos_q,
    sect_q,
    dz_q,
    dz_valid_q,
    revolution_q
);
    input wire clock;
    input wire rst_n;
    input wire timing_pulse_pin;
    input wire [3:0] addr;
    input wire [31:0] wr_data;
    input wire wr_en;
    input wire rd_en;
    output reg [31:0] rd_data_q;
    output reg [5:0] pos_q;
    output reg [4:0] sect_q;
    output reg dz_q;
    output reg dz_valid_q;
    output reg revolution_q;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function [10:0] dsie_index;
        input [4:0] s;
        input [5:0] p;
        begin
            dsie_index = s * `DSIE_SECT_SPAN + {5'h00, p} - 11'h001;
        end
    endfunction

    function dsie_maj;
        input a;
        input b;
        input c;
        begin
            dsie_maj = (a & b) | (a & c) | (b & c);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg tp_s1_q;
    reg tp_s2_q;
    reg tp_s3_q;
    reg run_q;
    reg [1:0] zlen_q;
    reg [10:0] trk_idx_q;
    reg trk_sel_q;
    reg [`DSIE_ZLINE_BITS-1:0] z_q;
    reg add_direction_select_q;
    reg [3:0] inc_q;
    reg [4:0] inc_bit_q;
    reg start_q;
    reg increment_adder_carry_delay_q;
    reg main_adder_carry_delay_q;

    wire step;
    wire r_bit;
    wire y_bit;
    wire [10:0] eng_idx;
    wire subtract_direction_select;
    reg z_tap;
    wire pick_pos;
    wire numeric;
    wire y_op;
    wire main_sum;
    wire inc_bit;
    wire inc_sum;
    wire overflow_recirculation_gate;
    wire z_in;
    wire r_wr;
    wire y_wr;
    wire bus_trk_wr;
    wire mem_we_r;
    wire mem_we_y;
    wire [10:0] mem_waddr;
    wire mem_wr_r;
    wire mem_wr_y;

    // ----------------------------------------------------------------
    // timing pulse synchroniser and step
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tp_s1_q <= 1'b0;
            tp_s2_q <= 1'b0;
            tp_s3_q <= 1'b0;
        end else begin
            tp_s1_q <= timing_pulse_pin;
            tp_s2_q <= tp_s1_q;
            tp_s3_q <= tp_s2_q;
        end
    end

    assign step = tp_s2_q & ~tp_s3_q;

    // ----------------------------------------------------------------
    // position and section counters
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= `DSIE_POS_FIRST;
            sect_q <= `DSIE_SECT_FIRST;
            revolution_q <= 1'b0;
        end else begin
            revolution_q <= 1'b0;
            if (step) begin
                if (pos_q == `DSIE_POS_LAST) begin // RULE17
                    pos_q <= `DSIE_POS_FIRST; // RULE1
                    if (sect_q == `DSIE_SECT_LAST) begin // RULE26
                        sect_q <= `DSIE_SECT_FIRST;
                        revolution_q <= 1'b1;
                    end else begin
                        sect_q <= sect_q + 5'h01; // RULE18
                    end
                end else begin
                    pos_q <= pos_q + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // tracks
    // ----------------------------------------------------------------
    assign eng_idx = dsie_index(sect_q, pos_q); // RULE2

    assign bus_trk_wr = wr_en & (addr == `DSIE_REG_TRK_DATA) & ~run_q;
    assign mem_waddr = run_q ? eng_idx : trk_idx_q;
    assign mem_we_r = run_q ? step : (bus_trk_wr & ~trk_sel_q);
    assign mem_we_y = run_q ? step : (bus_trk_wr & trk_sel_q);
    assign mem_wr_r = run_q ? r_wr : wr_data[0];
    assign mem_wr_y = run_q ? y_wr : wr_data[0];

    dsie_track_mem u_remainder_track (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(mem_we_r),
        .wr_addr(mem_waddr),
        .wr_bit(mem_wr_r),
        .rd_addr(eng_idx),
        .rd_bit(r_bit)
    );

    dsie_track_mem u_integrand_track (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(mem_we_y),
        .wr_addr(mem_waddr),
        .wr_bit(mem_wr_y),
        .rd_addr(eng_idx),
        .rd_bit(y_bit)
    );

    // ----------------------------------------------------------------
    // serial datapath
    // ----------------------------------------------------------------
    always @* begin
        case (zlen_q)
            `DSIE_ZLEN_48: z_tap = z_q[47];
            `DSIE_ZLEN_47: z_tap = z_q[46];
            default: z_tap = z_q[48]; // RULE15
        endcase
    end

    assign pick_pos = (pos_q <= `DSIE_POS_PICK_LAST); // RULE3 RULE4 RULE11
    assign subtract_direction_select = ~add_direction_select_q;
    // numeric from LSD after start through the MSD
    assign numeric = start_q & (pos_q >= `DSIE_POS_NUM_FIRST) & (pos_q <= `DSIE_POS_MSD); // RULE6
    assign y_op = subtract_direction_select ? ~y_bit : y_bit; // RULE5
    assign main_sum = r_bit ^ y_op ^ main_adder_carry_delay_q; // RULE22
    assign inc_bit = (inc_bit_q < 5'h04) ? inc_q[inc_bit_q[1:0]] : inc_q[3];
    assign inc_sum = y_bit ^ inc_bit ^ increment_adder_carry_delay_q; // RULE22
    assign overflow_recirculation_gate = (pos_q != `DSIE_POS_LAST);
    assign z_in = overflow_recirculation_gate ? z_tap : main_sum; // RULE19 RULE8 RULE16
    // msd and sign digits pass through the same adders
    assign r_wr = numeric ? main_sum : r_bit; // RULE20 RULE21 RULE7
    assign y_wr = (pos_q == `DSIE_POS_LAST) ? 1'b0 : (numeric ? inc_sum : y_bit); // RULE14 RULE13

    // ----------------------------------------------------------------
    // overflow line
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            z_q <= {`DSIE_ZLINE_BITS{1'b0}};
        end else if (wr_en && (addr == `DSIE_REG_CTRL) && wr_data[`DSIE_CTRL_CLR_Z]) begin
            z_q <= {`DSIE_ZLINE_BITS{1'b0}};
        end else if (step) begin
            if (run_q) begin
                z_q <= {z_q[`DSIE_ZLINE_BITS-2:0], z_in}; // RULE19
            end else begin
                z_q <= {z_q[`DSIE_ZLINE_BITS-2:0], z_tap};
            end
        end
    end

    // ----------------------------------------------------------------
    // code decode, increment counter, start flag, carries
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            add_direction_select_q <= 1'b0;
            inc_q <= 4'h0;
            inc_bit_q <= 5'h00;
            start_q <= 1'b0;
            increment_adder_carry_delay_q <= 1'b0;
            main_adder_carry_delay_q <= 1'b0;
        end else if (step && run_q) begin
            if (pick_pos && r_bit) begin
                add_direction_select_q <= z_tap; // RULE5
            end
            if (pick_pos && y_bit) begin
                if (z_tap) begin // RULE10 RULE24
                    if (inc_q != `DSIE_INC_MAX) begin // RULE9 RULE25
                        inc_q <= inc_q + 4'h1;
                    end
                end else begin
                    if (inc_q != `DSIE_INC_MIN) begin // RULE25
                        inc_q <= inc_q - 4'h1;
                    end
                end
            end
            if (pos_q == `DSIE_POS_PRESET) begin
                main_adder_carry_delay_q <= subtract_direction_select; // RULE23
            end
            if ((pos_q > `DSIE_POS_BLANK_A) && (pos_q != `DSIE_POS_LAST) && y_bit && !start_q) begin
                start_q <= 1'b1; // RULE12
            end
            if (numeric) begin
                main_adder_carry_delay_q <= dsie_maj(r_bit, y_op, main_adder_carry_delay_q); // RULE22
                increment_adder_carry_delay_q <= dsie_maj(y_bit, inc_bit,
                    increment_adder_carry_delay_q); // RULE22
                if (inc_bit_q != 5'h1F) begin
                    inc_bit_q <= inc_bit_q + 5'h01; // RULE10
                end
            end
            if (pos_q == `DSIE_POS_LAST) begin
                start_q <= 1'b0;
                inc_q <= 4'h0; // RULE25
                inc_bit_q <= 5'h00;
                increment_adder_carry_delay_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // output increment
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dz_q <= 1'b0;
            dz_valid_q <= 1'b0;
        end else begin
            dz_valid_q <= step & run_q & (pos_q == `DSIE_POS_LAST);
            if (step && run_q && (pos_q == `DSIE_POS_LAST)) begin
                dz_q <= main_sum; // RULE8
            end
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= `DSIE_RST_RUN;
            zlen_q <= `DSIE_RST_ZLEN;
            trk_idx_q <= `DSIE_RST_TRK_IDX;
            trk_sel_q <= 1'b0;
        end else if (wr_en) begin
            case (addr)
                `DSIE_REG_CTRL: begin
                    run_q <= wr_data[`DSIE_CTRL_RUN];
                    zlen_q <= wr_data[`DSIE_CTRL_ZLEN_HI:`DSIE_CTRL_ZLEN_LO];
                end
                `DSIE_REG_TRK_ADDR: begin
                    trk_idx_q <= wr_data[10:0];
                    trk_sel_q <= wr_data[`DSIE_TRK_SEL];
                end
                `DSIE_REG_TRK_DATA: begin
                    if (!run_q) begin
                        if (trk_idx_q == 11'h41F) begin
                            trk_idx_q <= 11'h000;
                        end else begin
                            trk_idx_q <= trk_idx_q + 11'h001;
                        end
                    end
                end
                default: begin
                    trk_sel_q <= trk_sel_q;
                end
            endcase
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 32'h00000000;
        end else if (rd_en) begin
            case (addr)
                `DSIE_REG_CTRL: rd_data_q <= {28'h0000000, 1'b0, zlen_q, run_q};
                `DSIE_REG_STATUS: rd_data_q <= {8'h00, inc_q, 2'h0, start_q,
                    add_direction_select_q, 3'h0, sect_q, 2'h0, pos_q};
                `DSIE_REG_TRK_ADDR: rd_data_q <= {19'h00000, trk_sel_q, 1'b0, trk_idx_q};
                `DSIE_REG_ZLINE_LO: rd_data_q <= z_q[31:0];
                `DSIE_REG_ZLINE_HI: rd_data_q <= {15'h0000, z_q[48:32]};
                default: rd_data_q <= 32'h00000000;
            endcase
        end else begin
            rd_data_q <= 32'h00000000;
        end
    end
endmodule // dsie_engine

// ### rtl/dsie_regs.vh
// dsie_regs.vh: constants of the drum serial integrator engine
// assumes inclusion by the engine and its track memory only
`ifndef DSIE_REGS_VH
`define DSIE_REGS_VH

// ----------------------------------------------------------------
// track geometry
// ----------------------------------------------------------------
`define DSIE_POS_LAST 6'd48
`define DSIE_POS_FIRST 6'd1
`define DSIE_POS_PICK_LAST 6'd22
`define DSIE_POS_BLANK_A 6'd23
`define DSIE_POS_PRESET 6'd24
`define DSIE_POS_NUM_FIRST 6'd25
`define DSIE_POS_MSD 6'd47
`define DSIE_SECT_LAST 5'd21
`define DSIE_SECT_FIRST 5'd0
`define DSIE_SECT_SPAN 11'd48
`define DSIE_TRACK_DEPTH 1056
`define DSIE_TRACK_AW 11

// ----------------------------------------------------------------
// overflow line lengths (zlen field codes)
// ----------------------------------------------------------------
`define DSIE_ZLEN_49 2'h0
`define DSIE_ZLEN_48 2'h1
`define DSIE_ZLEN_47 2'h2
`define DSIE_ZLINE_BITS 49

// ----------------------------------------------------------------
// increment counter limits
// ----------------------------------------------------------------
`define DSIE_INC_MAX 4'h7
`define DSIE_INC_MIN 4'h9

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DSIE_REG_CTRL 4'h0
`define DSIE_REG_STATUS 4'h1
`define DSIE_REG_TRK_ADDR 4'h2
`define DSIE_REG_TRK_DATA 4'h3
`define DSIE_REG_ZLINE_LO 4'h4
`define DSIE_REG_ZLINE_HI 4'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DSIE_CTRL_RUN 0
`define DSIE_CTRL_ZLEN_LO 1
`define DSIE_CTRL_ZLEN_HI 2
`define DSIE_CTRL_CLR_Z 3
`define DSIE_TRK_SEL 12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DSIE_RST_RUN 1'b0
`define DSIE_RST_ZLEN 2'h0
`define DSIE_RST_TRK_IDX 11'h000

`endif

// ### rtl/dsie_track_mem.v
// dsie_track_mem.v: one recirculating drum track, one bit per pulse position
// assumes one writer and one reader on the engine clock; read data registered
`timescale 1ns/1ps
`include "dsie_regs.vh"

module dsie_track_mem (
    clock,
    rst_n,
    wr_en,
    wr_addr,
    wr_bit,
    rd_addr,
    rd_bit
);
    input wire clock;
    input wire rst_n;
    input wire wr_en;
    input wire [`DSIE_TRACK_AW-1:0] wr_addr;
    input wire wr_bit;
    input wire [`DSIE_TRACK_AW-1:0] rd_addr;
    output reg rd_bit;

    reg mem [0:`DSIE_TRACK_DEPTH-1];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_bit;
        end
    end

    // ----------------------------------------------------------------
    // registered read
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_bit <= 1'b0;
        end else begin
            rd_bit <= mem[rd_addr];
        end
    end
endmodule // dsie_track_mem
